/* File: lpw_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LPW_CONSTS_SVH
`define LPW_CONSTS_SVH
`define LPW_OFS_CTRL 12'h000
`define LPW_OFS_EN 12'h004
`define LPW_OFS_POL 12'h008
`define LPW_OFS_STAT 12'h00C
`define LPW_OFS_IRQ_MASK 12'h010
`define LPW_OFS_STATE 12'h014
`define LPW_NSRC 9
`define LPW_SRC_CARD 0
`define LPW_SRC_RTS 1
`define LPW_SRC_WAKE_A 2
`define LPW_SRC_WAKE_B 3
`define LPW_SRC_OPT_A 4
`define LPW_EN_RST 9'h00F
`define LPW_POL_RST 9'h001
`define LPW_MASK_RST 9'h000
`define LPW_IDLE_NS 1000
`define LPW_CLK_NS 100
`define LPW_ARM_CYC 3
`define LPW_IDLE_CYC ((`LPW_IDLE_NS + `LPW_CLK_NS - 1) / `LPW_CLK_NS)
`endif

/* File: lpw_pkg.sv */
// Types of the low power wake controller
package lpw_pkg;
    typedef enum logic [1:0] {
        LPW_ACTIVE,
        LPW_IDLE_WAIT,
        LPW_SLEEP
    } lpw_state_t;
endpackage

/* File: lpw_wake_if.sv */
// Wake source bundle between detector and controller
`timescale 1ns/1ns
interface lpw_wake_if #(parameter int NSRC = 9);
    logic [NSRC-1:0] enable;
    logic [NSRC-1:0] rise_sel;
    logic [NSRC-1:0] edge_hit;
    logic wake_req;
    modport ctrl (output enable, output rise_sel, input edge_hit,
        input wake_req);
    modport det (input enable, input rise_sel, output edge_hit,
        output wake_req);
endinterface

/* File: lpw_edge_det.sv */
// Synchroniser and selectable edge detector for all wake sources
`timescale 1ns/1ns
module lpw_edge_det #(
    parameter int NSRC = 9
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [NSRC-1:0] src_i,
    lpw_wake_if.det wif
);
    logic [NSRC-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge clk_i or posedge sys_rst_i)
            begin
                if (sys_rst_i)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end
                else if (ce_i)
                begin
                    s1_reg <= src_i[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            // Rising or falling edge as selected, gated by enable
            assign hit[g] = wif.enable[g] & (wif.rise_sel[g] ?
                (s2_reg & ~s3_reg) : (~s2_reg & s3_reg));
        end
    endgenerate
    assign wif.edge_hit = hit;
    assign wif.wake_req = |hit;
endmodule

/* File: lpw_ahb_slave.sv */
// AHB-Lite slave front end, zero wait state
`timescale 1ns/1ns
module lpw_ahb_slave (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    output logic wr_o,
    output logic rd_o,
    output logic [11:0] addr_o
);
    logic wr_reg;
    logic [11:0] addr_reg;
    logic req;
    assign req = hsel_i & hready_i & htrans_i[1] & ce_i;
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wr_reg <= 1'b0;
            addr_reg <= 12'h000;
        end
        else if (ce_i)
        begin
            wr_reg <= req & hwrite_i;
            if (req)
                addr_reg <= haddr_i;
        end
    end
    assign wr_o = wr_reg & ce_i;
    assign rd_o = req & ~hwrite_i;
    assign addr_o = rd_o ? haddr_i : addr_reg;
endmodule

/* File: lpw_wake_ctrl.sv */
// Low power wake controller: sleep entry, wake sources, registers
// Operation
// - Enter low power unprompted after idle; stay until enabled wake fires.
// - Card presence rising edge wakes the device by default.
// - Host send request line falling edge wakes by default.
// - Both dedicated wake inputs wake on falling edge by default.
// - Software selects edge polarity of the dedicated wake inputs.
// - Software disables each dedicated wake input separately.
// - Five optional wake pins start disabled; software enables each.
`timescale 1ns/1ns
`include "lpw_consts.svh"
module lpw_wake_ctrl #(
    parameter int NSRC = `LPW_NSRC,
    parameter int IDLE_CYC = `LPW_IDLE_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic card_present_i,
    input wire logic host_send_request_line_i,
    input wire logic dedicated_wake_input_a_i,
    input wire logic dedicated_wake_input_b_i,
    input wire logic [4:0] optional_wake_pins_i,
    input wire logic activity_i,
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic low_power_o,
    output logic wake_pulse_o,
    output logic irq_o
);
    localparam logic [NSRC-1:0] EN_RST = NSRC'(`LPW_EN_RST);
    localparam logic [NSRC-1:0] POL_RST = NSRC'(`LPW_POL_RST);
    localparam logic [NSRC-1:0] MASK_RST = NSRC'(`LPW_MASK_RST);
    localparam logic [15:0] IDLE_MAX = 16'(IDLE_CYC - 1);
    localparam logic [1:0] ARM_MAX = 2'(`LPW_ARM_CYC);

    lpw_wake_if #(.NSRC(NSRC)) wif ();
    lpw_pkg::lpw_state_t state_reg;
    logic [NSRC-1:0] en_reg;
    logic [NSRC-1:0] pol_reg;
    logic [NSRC-1:0] stat_reg;
    logic [NSRC-1:0] mask_reg;
    logic sleep_req_reg;
    logic [15:0] idle_reg;
    logic [31:0] rdata_reg;
    logic [NSRC-1:0] src;
    logic bus_wr;
    logic bus_rd;
    logic [11:0] bus_addr;
    logic [NSRC-1:0] wdat;
    lpw_pkg::lpw_state_t state_next;
    logic [NSRC-1:0] stat_next;
    logic [15:0] idle_next;
    logic [31:0] rdata_next;
    logic irq_next;
    logic [1:0] arm_reg;
    logic armed;
    logic [NSRC-1:0] live_hit;
    logic live_wake;
    logic wr_ctrl;
    logic wr_en;
    logic wr_pol;
    logic wr_stat;
    logic wr_mask;

    assign src = {optional_wake_pins_i, dedicated_wake_input_b_i,
        dedicated_wake_input_a_i, host_send_request_line_i,
        card_present_i};
    assign wdat = hwdata_i[NSRC-1:0];

    lpw_ahb_slave u_bus (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hready_i(hready_i),
        .wr_o(bus_wr),
        .rd_o(bus_rd),
        .addr_o(bus_addr)
    );

    lpw_edge_det #(.NSRC(NSRC)) u_det (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .src_i(src),
        .wif(wif)
    );

    assign wif.enable = en_reg;
    assign wif.rise_sel = pol_reg;

    // Register write strobes, one per writable register
    always_comb
    begin
        wr_ctrl = 1'b0;
        wr_en = 1'b0;
        wr_pol = 1'b0;
        wr_stat = 1'b0;
        wr_mask = 1'b0;
        if (bus_wr)
        begin
            case (bus_addr)
                `LPW_OFS_CTRL: wr_ctrl = 1'b1;
                `LPW_OFS_EN: wr_en = 1'b1;
                `LPW_OFS_POL: wr_pol = 1'b1;
                `LPW_OFS_STAT: wr_stat = 1'b1;
                `LPW_OFS_IRQ_MASK: wr_mask = 1'b1;
                default: wr_ctrl = 1'b0;
            endcase
        end
    end

    // Hold off edge hits until the synchronisers carry real pin levels,
    // so the reset value of the chain is never taken for an edge
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            arm_reg <= 2'h0;
        end
        else if (ce_i && arm_reg != ARM_MAX)
        begin
            arm_reg <= arm_reg + 2'h1;
        end
    end

    assign armed = arm_reg == ARM_MAX;
    assign live_hit = armed ? wif.edge_hit : '0;
    assign live_wake = armed & wif.wake_req;

    // Enable register: card, request, dedicated and optional sources
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            en_reg <= EN_RST;
        end
        else if (ce_i && wr_en)
        begin
            en_reg <= wdat;
        end
    end

    // Polarity register: one selects rising edge
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            pol_reg <= POL_RST;
        end
        else if (ce_i && wr_pol)
        begin
            pol_reg <= wdat;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            mask_reg <= MASK_RST;
        end
        else if (ce_i && wr_mask)
        begin
            mask_reg <= wdat;
        end
    end

    // Sticky wake status per source, set beats write-one clear
    genvar b;
    generate
        for (b = 0; b < NSRC; b++)
        begin : g_stat
            assign stat_next[b] = live_hit[b] |
                (stat_reg[b] & ~(wr_stat & wdat[b]));
        end
    endgenerate

    // Status register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            stat_reg <= '0;
        end
        else if (ce_i)
        begin
            stat_reg <= stat_next;
        end
    end

    // Optional software request to sleep at once, taken only while in LPW_IDLE_WAIT
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            sleep_req_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            sleep_req_reg <= wr_ctrl && hwdata_i[0];
        end
    end

    // Idle counter, runs only while waiting to sleep
    always_comb
    begin
        idle_next = idle_reg;
        if (state_reg != lpw_pkg::LPW_IDLE_WAIT || activity_i)
        begin
            idle_next = 16'h0000;
        end
        else if (idle_reg != IDLE_MAX)
        begin
            idle_next = idle_reg + 16'h0001;
        end
    end

    // Idle counter register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            idle_reg <= 16'h0000;
        end
        else if (ce_i)
        begin
            idle_reg <= idle_next;
        end
    end

    // Power state machine, next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            lpw_pkg::LPW_ACTIVE:
            begin
                if (!activity_i)
                    state_next = lpw_pkg::LPW_IDLE_WAIT;
            end
            lpw_pkg::LPW_IDLE_WAIT:
            begin
                if (activity_i || live_wake)
                    state_next = lpw_pkg::LPW_ACTIVE;
                else if (idle_reg == IDLE_MAX || sleep_req_reg)
                    state_next = lpw_pkg::LPW_SLEEP;
            end
            lpw_pkg::LPW_SLEEP:
            begin
                if (live_wake)
                    state_next = lpw_pkg::LPW_ACTIVE;
            end
            default:
                state_next = lpw_pkg::LPW_ACTIVE;
        endcase
    end

    // Power state register
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= lpw_pkg::LPW_ACTIVE;
        end
        else if (ce_i)
        begin
            state_reg <= state_next;
        end
    end

    // Wake pulse on leaving sleep
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            wake_pulse_o <= 1'b0;
        end
        else if (ce_i)
        begin
            wake_pulse_o <= state_reg == lpw_pkg::LPW_SLEEP &&
                live_wake;
        end
    end

    // Read data selection
    always_comb
    begin
        case (bus_addr)
            `LPW_OFS_EN: rdata_next = 32'(en_reg);
            `LPW_OFS_POL: rdata_next = 32'(pol_reg);
            `LPW_OFS_STAT: rdata_next = 32'(stat_reg);
            `LPW_OFS_IRQ_MASK: rdata_next = 32'(mask_reg);
            `LPW_OFS_STATE: rdata_next = 32'(state_reg);
            default: rdata_next = 32'h00000000;
        endcase
    end

    // Read data register, holds until the next read
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rdata_reg <= 32'h00000000;
        end
        else if (ce_i && bus_rd)
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Interrupt level, registered from status and mask
    assign irq_next = |(stat_reg & mask_reg);

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_o <= irq_next;
        end
    end

    assign hrdata_o = rdata_reg;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign low_power_o = state_reg == lpw_pkg::LPW_SLEEP;
endmodule

/* File: lpw_wake_ctrl_checker.sv */
// Port assertions for the wake controller
`timescale 1ns/1ns
`include "lpw_consts.svh"
module lpw_wake_ctrl_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic card_present_i,
    input wire logic host_send_request_line_i,
    input wire logic dedicated_wake_input_a_i,
    input wire logic dedicated_wake_input_b_i,
    input wire logic [4:0] optional_wake_pins_i,
    input wire logic hsel_i,
    input wire logic [11:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic low_power_o,
    input wire logic wake_pulse_o
);
    logic [3:0] quiet_reg;
    logic dirty_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Cycles since any wake line last moved
    always_ff @(posedge clk_i or posedge sys_rst_i)
        if (sys_rst_i)
            quiet_reg <= 4'h0;
        else if ($changed({card_present_i, host_send_request_line_i,
            dedicated_wake_input_a_i, dedicated_wake_input_b_i,
            optional_wake_pins_i}))
            quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hF)
            quiet_reg <= quiet_reg + 4'h1;
    // Set once enable or polarity is written
    always_ff @(posedge clk_i or posedge sys_rst_i)
        if (sys_rst_i)
            dirty_reg <= 1'b0;
        else if (hsel_i && htrans_i[1] && hwrite_i &&
            (haddr_i == `LPW_OFS_EN || haddr_i == `LPW_OFS_POL))
            dirty_reg <= 1'b1;
    AST_SLEEP_HOLD:
        assert property (low_power_o && quiet_reg > 4'h3 |=> low_power_o)
        else $error("sleep left with quiet inputs");
    AST_WAKE_FAST:
        assert property ($fell(low_power_o) |-> quiet_reg >= 4'h1)
        else $error("wake faster than synchroniser");
    AST_WAKE_CAUSE:
        assert property ($fell(low_power_o) |-> quiet_reg <= 4'h5)
        else $error("wake without a recent edge");
    AST_PULSE_AFTER:
        assert property ($fell(low_power_o) |-> wake_pulse_o)
        else $error("no pulse after wake");
    AST_PULSE_ONE:
        assert property (wake_pulse_o |=> !wake_pulse_o)
        else $error("pulse longer than one cycle");
    AST_CARD_DEF:
        assert property (!dirty_reg && low_power_o && $rose(card_present_i)
            |-> ##[2:5] !low_power_o)
        else $error("card insertion did not wake");
    AST_RTS_DEF:
        assert property (!dirty_reg && low_power_o &&
            $fell(host_send_request_line_i) |-> ##[2:5] !low_power_o)
        else $error("send request did not wake");
    AST_WAKEA_DEF:
        assert property (!dirty_reg && low_power_o &&
            $fell(dedicated_wake_input_a_i) |-> ##[2:5] !low_power_o)
        else $error("wake input a did not wake");
    cover property (low_power_o ##1 !low_power_o);
    cover property (wake_pulse_o && dirty_reg);
    cover property (low_power_o && $rose(card_present_i));
endmodule

/* File: lpw_far_model.sv */
// Far side: card connector, host send request and sensor alarm lines
`timescale 1ns/1ns
module lpw_far_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic tog_i,
    input wire logic [3:0] sel_i,
    output logic [8:0] lvl_o
);
    // Request and alarms idle high, card out, pins low
    always_ff @(posedge clk_i or posedge sys_rst_i)
        if (sys_rst_i)
            lvl_o <= 9'h00E;
        else if (tog_i)
            lvl_o[sel_i] <= ~lvl_o[sel_i];
endmodule

/* File: lpw_wake_ctrl_test.sv */
// Self-checking bench for the wake controller
`timescale 1ns/1ns
`include "lpw_consts.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module lpw_wake_ctrl_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic act, hsel, hwrite, tog, rd_dp, hrdy, hresp, lp, wp, irq, ce;
    logic [1:0] htrans;
    logic [3:0] sel;
    logic [11:0] haddr;
    logic [31:0] hwdata, hrdata, seed;
    logic [8:0] lvl, en_s, pol_s, m_s;
    logic [31:0] q[$];
    int n_mismatch, tests_run, s;
    int fx[7] = '{0, 0, 1, 1, 2, 3, 4};
    always #50 clk_i = ~clk_i;
    lpw_far_model u_lpw_far_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .tog_i(tog), .sel_i(sel), .lvl_o(lvl));
    lpw_wake_ctrl #(.IDLE_CYC(2)) u_lpw_wake_ctrl (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .ce_i(ce), .card_present_i(lvl[0]),
        .host_send_request_line_i(lvl[1]), .dedicated_wake_input_a_i(lvl[2]),
        .dedicated_wake_input_b_i(lvl[3]), .optional_wake_pins_i(lvl[8:4]),
        .activity_i(act), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .low_power_o(lp), .wake_pulse_o(wp), .irq_o(irq));
    // Read data phase monitor
    always @(posedge clk_i)
    begin
        if (rd_dp)
        begin
            `CHK(hrdata, q.pop_front())
            `CHK(hresp, 1'b0)
        end
        rd_dp <= hsel && htrans[1] && !hwrite && hrdy;
    end
    task close_out;
        $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task tmo;
        n_mismatch++;
        $display("ERROR %0t wait ran out", $time);
        close_out();
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge clk_i); n++; end while (hrdy !== 1'b1 && n < 20);
        if (n >= 20)
            tmo();
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk_i); n++; end while (hrdy !== 1'b1 && n < 40);
        if (n >= 40)
            tmo();
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task cfg;
        seed = $urandom;
        en_s = seed[8:0];
        bus(1'b1, `LPW_OFS_EN, seed);
        seed = $urandom;
        pol_s = seed[8:0];
        bus(1'b1, `LPW_OFS_POL, seed);
        seed = $urandom;
        m_s = seed[8:0];
        bus(1'b1, `LPW_OFS_IRQ_MASK, seed);
        rd(`LPW_OFS_POL, {23'h0, pol_s});
    endtask
    task wake_case(input int k);
        int n;
        logic exp, woke;
        n = 0;
        woke = 1'b0;
        while (lp !== 1'b1 && n < 30)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 30)
            tmo();
        exp = en_s[k] && (pol_s[k] == !lvl[k]);
        sel <= k[3:0];
        tog <= 1'b1;
        @(posedge clk_i);
        tog <= 1'b0;
        repeat (8)
        begin
            @(posedge clk_i);
            if (wp === 1'b1)
                woke = 1'b1;
        end
        `CHK(woke, exp)
        if (!exp)
            `CHK(lp, 1'b1)
        `CHK(irq, exp && m_s[k])
        rd(`LPW_OFS_STAT, exp ? 32'h1 << k : 32'h0);
        bus(1'b1, `LPW_OFS_STAT, 32'h1FF);
        @(posedge clk_i);
        #1;
        `CHK(irq, 1'b0)
        $display("source %0d case done", k);
    endtask
    initial
    begin
        {hsel, hwrite, tog, rd_dp, htrans, sel, haddr, hwdata} = '0;
        act = 1'b1;
        ce = 1'b1;
        n_mismatch = 0;
        tests_run = 0;
        en_s = `LPW_EN_RST;
        pol_s = `LPW_POL_RST;
        m_s = `LPW_MASK_RST;
        seed = $urandom(77);
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`LPW_OFS_EN, 32'h00F);
        rd(`LPW_OFS_POL, 32'h001);
        rd(`LPW_OFS_IRQ_MASK, 32'h000);
        rd(12'h020, 32'h0);
        act <= 1'b0;
        $display("register reset case done");
        foreach (fx[i])
            wake_case(fx[i]);
        act <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(lp, 1'b1)
        rd(`LPW_OFS_STATE, 32'h2);
        wake_case(0);
        rd(`LPW_OFS_STATE, 32'h0);
        ce <= 1'b0;
        act <= 1'b0;
        repeat (5) @(posedge clk_i);
        `CHK(lp, 1'b0)
        ce <= 1'b1;
        repeat (5) @(posedge clk_i);
        `CHK(lp, 1'b1)
        $display("hold and freeze case done");
        repeat (30)
        begin
            if ($urandom % 3 == 0)
                cfg();
            s = $urandom % 9;
            wake_case(s);
        end
        rd(`LPW_OFS_EN, {23'h0, en_s});
        close_out();
    end
endmodule
bind lpw_wake_ctrl lpw_wake_ctrl_checker u_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .card_present_i(card_present_i),
    .host_send_request_line_i(host_send_request_line_i),
    .dedicated_wake_input_a_i(dedicated_wake_input_a_i),
    .dedicated_wake_input_b_i(dedicated_wake_input_b_i),
    .optional_wake_pins_i(optional_wake_pins_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .low_power_o(low_power_o), .wake_pulse_o(wake_pulse_o));
